// >>> reset_fanout_pkg.sv
// ----------------------------------------------------------------
// shared constants and types
// ----------------------------------------------------------------
package reset_fanout_pkg;
  // port numbering: upstream first, then the downstream range
  localparam int UP_PORT = 0;
  localparam int DN_FIRST = 1;
  localparam int DN_LAST = 2;
  localparam int NUM_PORTS = 3;
  localparam int NUM_FANOUT = 3;
  // clock and downstream hold timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int HOLD_TIME_US = 100;
  localparam int HOLD_CYCLES = (HOLD_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_W = 15;
  // reset values
  localparam logic RESET_ACTIVE = 1'h0;
  localparam logic PRESENT_NONE = 1'h1;
  localparam logic [HOLD_W-1:0] COUNT_ZERO = 15'h0000;
  localparam logic [HOLD_W-1:0] COUNT_ONE = 15'h0001;
  // one fanout output group, true and complement legs
  typedef struct packed {
    logic [NUM_FANOUT-1:0] pos;
    logic [NUM_FANOUT-1:0] neg;
  } refclk_pair_t;
  // per downstream port hold sequencer states
  typedef enum logic [1:0] {
    HOLD_ST = 2'h1,
    RUN_ST = 2'h2
  } hold_state_t;
endpackage

// >>> port_reset_hold.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// one downstream port reset sequencer
// ----------------------------------------------------------------
module port_reset_hold
  import reset_fanout_pkg::*;
#(
  parameter logic [HOLD_W-1:0] HOLD = HOLD_W'(HOLD_CYCLES)
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // events
  input wire logic plug_i,
  // reset to the device on this port
  output logic downstream_port_reset_n_o
);
  hold_state_t state;
  hold_state_t next_state;
  logic [HOLD_W-1:0] count;
  logic [HOLD_W-1:0] next_count;
  logic next_reset_n;

  // hold the port reset for HOLD cycles after system reset or a plug
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_reset_n = downstream_port_reset_n_o;
    case (state)
      HOLD_ST:
      begin
        next_reset_n = RESET_ACTIVE;
        if (count >= HOLD - COUNT_ONE)
        begin
          next_state = RUN_ST;
          next_reset_n = ~RESET_ACTIVE;
        end
        else
        begin
          next_count = count + COUNT_ONE;
        end
      end
      RUN_ST:
      begin
        next_reset_n = ~RESET_ACTIVE;
      end
      default:
      begin
        next_state = HOLD_ST;
        next_reset_n = RESET_ACTIVE;
      end
    endcase
    // a new plug restarts the hold, whatever the state
    if (plug_i)
    begin
      next_state = HOLD_ST;
      next_count = COUNT_ZERO;
      next_reset_n = RESET_ACTIVE;
    end
  end

  // state registers, reset asserts the port reset
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= HOLD_ST;
      count <= COUNT_ZERO;
      downstream_port_reset_n_o <= RESET_ACTIVE;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      downstream_port_reset_n_o <= next_reset_n;
    end
  end
endmodule
`default_nettype wire

// >>> switch_reset_and_clock_fanout.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R1] system reset clears all but sticky state
// [R2] downstream resets low on system reset, plug
// [R3] one independent reset per downstream port
// [R4] port 0 upstream, ports 1-2 downstream
// [R5] power-down strap high disables all fanout
// [R6] enabled buffer copies reference to three outputs
// [R7] plug holds port reset fixed cycles, releases
module switch_reset_and_clock_fanout
#(
  parameter logic [reset_fanout_pkg::HOLD_W-1:0] HOLD = reset_fanout_pkg::HOLD_W'(reset_fanout_pkg::HOLD_CYCLES)
)
(
  // clock and system reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // power-on reset for sticky state
  input wire logic pwr_on_nrst_i,
  // straps and presence pins, active low presence
  input wire logic refclk_buffer_powerdown_i,
  input wire logic [reset_fanout_pkg::DN_LAST:reset_fanout_pkg::DN_FIRST] present_n_i,
  // reference clock into the buffer
  input wire logic refclk_buffer_in_pos_i,
  // downstream device resets
  output logic [reset_fanout_pkg::DN_LAST:reset_fanout_pkg::DN_FIRST] downstream_port_reset_n_o,
  // sticky record of a plug on each downstream port
  output logic [reset_fanout_pkg::DN_LAST:reset_fanout_pkg::DN_FIRST] plug_seen_o,
  // reference clock fanout
  output reset_fanout_pkg::refclk_pair_t refclk_fanout_o
);
  import reset_fanout_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [DN_LAST:DN_FIRST] pres_meta;
  logic [DN_LAST:DN_FIRST] pres_sync;
  logic [DN_LAST:DN_FIRST] pres_prev;
  logic pd_meta;
  logic pd_sync;
  logic ref_meta;
  logic ref_sync;
  logic [DN_LAST:DN_FIRST] next_pres_meta;
  logic [DN_LAST:DN_FIRST] next_pres_sync;
  logic [DN_LAST:DN_FIRST] next_pres_prev;
  logic next_pd_meta;
  logic next_pd_sync;
  logic next_ref_meta;
  logic next_ref_sync;
  logic [DN_LAST:DN_FIRST] plug;

  // two flops per pin, then one more for the presence edge
  always_comb
  begin
    next_pres_meta = present_n_i;
    next_pres_sync = pres_meta;
    next_pres_prev = pres_sync;
    next_pd_meta = refclk_buffer_powerdown_i;
    next_pd_sync = pd_meta;
    next_ref_meta = refclk_buffer_in_pos_i;
    next_ref_sync = ref_meta;
  end

  // all of these clear on system reset
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pres_meta <= {(DN_LAST-DN_FIRST+1){PRESENT_NONE}}; // R1
      pres_sync <= {(DN_LAST-DN_FIRST+1){PRESENT_NONE}};
      pres_prev <= {(DN_LAST-DN_FIRST+1){PRESENT_NONE}};
      pd_meta <= 1'h1;
      pd_sync <= 1'h1;
      ref_meta <= 1'h0;
      ref_sync <= 1'h0;
    end
    else
    begin
      pres_meta <= next_pres_meta;
      pres_sync <= next_pres_sync;
      pres_prev <= next_pres_prev;
      pd_meta <= next_pd_meta;
      pd_sync <= next_pd_sync;
      ref_meta <= next_ref_meta;
      ref_sync <= next_ref_sync;
    end
  end

  // a plug is presence going from absent to present
  assign plug = pres_prev & ~pres_sync;

  // ----------------------------------------------------------------
  // downstream port resets
  // ----------------------------------------------------------------
  // one sequencer per downstream port only, none for upstream
  for (genvar p = DN_FIRST; p <= DN_LAST; p++) // R4
  begin : g_port
    port_reset_hold #(
      .HOLD(HOLD)
    ) u_hold (
      .clk_i(clk_i),
      .nrst_i(nrst_i), // R2
      .plug_i(plug[p]), // R3 R7
      .downstream_port_reset_n_o(downstream_port_reset_n_o[p])
    );
  end

  // ----------------------------------------------------------------
  // sticky plug record
  // ----------------------------------------------------------------
  logic [DN_LAST:DN_FIRST] next_plug_seen;

  // survives system reset, cleared only at power-on
  always_comb
  begin
    next_plug_seen = plug_seen_o | plug;
  end

  always_ff @(posedge clk_i or negedge pwr_on_nrst_i)
  begin
    if (!pwr_on_nrst_i)
    begin
      plug_seen_o <= '0;
    end
    else
    begin
      plug_seen_o <= next_plug_seen; // R1
    end
  end

  // ----------------------------------------------------------------
  // reference clock fanout
  // ----------------------------------------------------------------
  refclk_pair_t next_fanout;

  // both legs parked low while powered down
  always_comb
  begin
    next_fanout.pos = '0;
    next_fanout.neg = '0;
    if (!pd_sync) // R5
    begin
      next_fanout.pos = {NUM_FANOUT{ref_sync}}; // R6
      next_fanout.neg = {NUM_FANOUT{~ref_sync}};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      refclk_fanout_o <= '0;
    end
    else
    begin
      refclk_fanout_o <= next_fanout;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // reset and sticky behaviour
  a_reset_clears_state: assert property (@(posedge clk_i) !nrst_i |-> (refclk_fanout_o == '0) && pd_sync) // R1
    else $error("state not cleared under system reset");

  a_sticky_survives: assert property (@(posedge clk_i) disable iff (!pwr_on_nrst_i) // R1
    !nrst_i && $past(plug_seen_o) != '0 |-> plug_seen_o == $past(plug_seen_o))
    else $error("sticky record lost in system reset");

  a_sysreset_holds_down: assert property (@(posedge clk_i) !nrst_i |-> downstream_port_reset_n_o == '0) // R2
    else $error("downstream reset released in system reset");

  // reference fanout
  a_pd_disables: assert property (@(posedge clk_i) disable iff (!nrst_i) // R5
    pd_sync |=> refclk_fanout_o == '0)
    else $error("fanout active while powered down");

  a_fanout_copies: assert property (@(posedge clk_i) disable iff (!nrst_i) // R6
    !pd_sync |=> refclk_fanout_o.pos == {NUM_FANOUT{$past(ref_sync)}} &&
    refclk_fanout_o.neg == ~refclk_fanout_o.pos)
    else $error("fanout not following reference");

  // per downstream port sequencing
  for (genvar q = DN_FIRST; q <= DN_LAST; q++)
  begin : g_chk
    a_plug_holds_reset: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2 R7
      plug[q] |=> !downstream_port_reset_n_o[q] [*8])
      else $error("plug did not hold port reset");

    a_port_independent: assert property (@(posedge clk_i) disable iff (!nrst_i) // R3
      plug[q] && !plug[DN_FIRST + DN_LAST - q] && downstream_port_reset_n_o[DN_FIRST + DN_LAST - q]
      |=> downstream_port_reset_n_o[DN_FIRST + DN_LAST - q])
      else $error("plug on one port reset the other");

    a_no_spurious_reset: assert property (@(posedge clk_i) disable iff (!nrst_i) // R7
      downstream_port_reset_n_o[q] && !plug[q] |=> downstream_port_reset_n_o[q])
      else $error("port reset without a plug");

    a_plug_sets_sticky: assert property (@(posedge clk_i) disable iff (!pwr_on_nrst_i) // R1
      plug[q] |=> plug_seen_o[q])
      else $error("plug not recorded in sticky state");

    a_release_after_hold: assert property (@(posedge clk_i) disable iff (!nrst_i) // R7
      $rose(downstream_port_reset_n_o[q]) |-> !$past(downstream_port_reset_n_o[q], 8))
      else $error("port reset released before its hold");

    // a plug, the hold, then the release
    c_plug_release: cover property (@(posedge clk_i) disable iff (!nrst_i)
      plug[q] ##1 !downstream_port_reset_n_o[q] ##[1:1000] downstream_port_reset_n_o[q]);

    // a second plug lands while the port is still held
    c_plug_restart: cover property (@(posedge clk_i) disable iff (!nrst_i)
      plug[q] ##1 !downstream_port_reset_n_o[q] ##[1:16] plug[q]);
  end

  c_fanout_runs: cover property (@(posedge clk_i) disable iff (!nrst_i)
    !pd_sync ##1 refclk_fanout_o.pos[0] ##1 !refclk_fanout_o.pos[0]);

  c_powerdown: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(pd_sync));
endmodule
`default_nettype wire

// >>> slot_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// downstream slots and reference source
// ----------------------------------------------------------------
module slot_partner
(
  // clock
  input wire logic clk_i,
  // bench commands
  input wire logic [2:1] insert_i,
  input wire logic ref_run_i,
  // pins toward the switch
  output logic [2:1] present_n_o,
  output logic ref_o
);
  integer seed = 32'hE3546ED8;
  logic [31:0] rnd;
  initial
  begin
    present_n_o = 2'h3;
    ref_o = 1'h0;
  end
  // presence low while a card sits in a slot, reference random
  always @(posedge clk_i)
  begin
    rnd = $random(seed);
    present_n_o <= ~insert_i;
    ref_o <= ref_run_i & rnd[0];
  end
endmodule
`default_nettype wire

// >>> tb_switch_reset_and_clock_fanout.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module tb_switch_reset_and_clock_fanout;
  import reset_fanout_pkg::*;
  localparam logic [HOLD_W-1:0] HOLD = 15'h0010;
  logic clk_i = 1'h0;
  logic nrst_i = 1'h1;
  logic pwr = 1'h1;
  logic pd = 1'h1;
  logic ref_run = 1'h0;
  logic chk_fan = 1'h0;
  logic [2:1] insert = 2'h0;
  logic [2:1] present_n;
  logic [2:1] dn_n;
  logic [2:1] seen;
  logic ref_in;
  logic [1:0] pd_q;
  logic [1:0] rf_q;
  refclk_pair_t fanout;
  refclk_pair_t exp_fan;
  logic [2:1] pres_q [$];
  int hold_left [2:1];
  logic [2:1] plug_m;
  logic [2:1] exp_dn;
  logic [2:1] exp_seen;
  int miscompares = 0;
  int comparisons = 0;
  always #2 clk_i = ~clk_i;
  slot_partner u_slot_partner (.clk_i(clk_i), .insert_i(insert), .ref_run_i(ref_run),
    .present_n_o(present_n), .ref_o(ref_in));
  switch_reset_and_clock_fanout #(.HOLD(HOLD)) u_switch_reset_and_clock_fanout (.clk_i(clk_i),
    .nrst_i(nrst_i), .pwr_on_nrst_i(pwr), .refclk_buffer_powerdown_i(pd), .present_n_i(present_n),
    .refclk_buffer_in_pos_i(ref_in), .downstream_port_reset_n_o(dn_n), .plug_seen_o(seen),
    .refclk_fanout_o(fanout));
  // fanout model: two sync stages then the output stage
  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      pd_q <= 2'h3;
      rf_q <= 2'h0;
      exp_fan <= '0;
    end
    else
    begin
      pd_q <= {pd_q[0], pd};
      rf_q <= {rf_q[0], ref_in};
      exp_fan <= pd_q[1] ? 6'h00 : {{3{rf_q[1]}}, {3{~rf_q[1]}}};
    end
  // port reset model: three stage presence pipeline, one hold count per port
  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      pres_q = '{2'h3, 2'h3, 2'h3};
      hold_left = '{int'(HOLD), int'(HOLD)};
      exp_dn <= 2'h0;
    end
    else
    begin
      plug_m = pres_q[2] & ~pres_q[1];
      for (int p = 1; p <= 2; p++)
        hold_left[p] = plug_m[p] ? int'(HOLD) : (hold_left[p] > 0 ? hold_left[p] - 1 : 0);
      exp_dn <= {hold_left[2] == 0, hold_left[1] == 0};
      exp_seen <= exp_seen | plug_m;
      pres_q.push_front(present_n);
      void'(pres_q.pop_back());
    end
  // sticky model clears only at power-on
  always @(negedge pwr)
    exp_seen <= 2'h0;
  // every result against the models, between clock edges
  always @(negedge clk_i)
    if (chk_fan)
    begin
      check_fanout(exp_fan, fanout);
      check_ports("port_reset_model", exp_dn, dn_n);
      check_ports("plug_seen_model", exp_seen, seen);
    end
  task automatic check_fanout(input refclk_pair_t e, input refclk_pair_t g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error refclk_fanout expected %h seen %h", e, g);
    end
  endtask
  task automatic check_ports(input string what, input logic [1:0] e, input logic [1:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %0s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #4000;
    miscompares++;
    $display("Error watchdog expected done seen hang");
    conclude();
  end
  // main sequence
  initial
  begin
    // falling edges so that every asynchronous reset really fires
    #1;
    nrst_i <= 1'h0;
    pwr <= 1'h0;
    wait_n(8);
    pwr <= 1'h1;
    nrst_i <= 1'h1;
    ref_run <= 1'h1;
    chk_fan <= 1'h1;
    wait_n(2);
    check_ports("port_reset", 2'h0, dn_n);
    check_ports("plug_seen", 2'h0, seen);
    wait_n(HOLD + 4);
    check_ports("port_reset", 2'h3, dn_n);
    $display("test reset_release done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      pd <= i[0];
      wait_n(6);
    end
    $display("test fanout_strap done");
    // plug port 1, pull and replug during its hold
    @(posedge clk_i);
    insert <= 2'h1;
    wait_n(7);
    check_ports("port_reset", 2'h2, dn_n);
    @(posedge clk_i);
    insert <= 2'h0;
    wait_n(3);
    @(posedge clk_i);
    insert <= 2'h1;
    wait_n(15);
    check_ports("port_reset", 2'h2, dn_n);
    wait_n(18);
    check_ports("port_reset", 2'h3, dn_n);
    $display("test plug_restart done");
    // plug port 2, removal in its hold is ignored
    @(posedge clk_i);
    insert <= 2'h3;
    wait_n(7);
    check_ports("port_reset", 2'h1, dn_n);
    @(posedge clk_i);
    insert <= 2'h1;
    wait_n(6);
    check_ports("port_reset", 2'h1, dn_n);
    wait_n(16);
    check_ports("port_reset", 2'h3, dn_n);
    check_ports("plug_seen", 2'h3, seen);
    insert <= 2'h0;
    $display("test plug_remove done");
    // system reset mid-run keeps sticky state
    @(posedge clk_i);
    nrst_i <= 1'h0;
    wait_n(3);
    check_ports("port_reset", 2'h0, dn_n);
    check_ports("plug_seen", 2'h3, seen);
    @(posedge clk_i);
    nrst_i <= 1'h1;
    wait_n(HOLD + 4);
    check_ports("port_reset", 2'h3, dn_n);
    @(posedge clk_i);
    pwr <= 1'h0;
    wait_n(2);
    check_ports("plug_seen", 2'h0, seen);
    $display("test system_reset done");
    conclude();
  end
endmodule
`default_nettype wire
